// *** rtl/rsc_regs.vh ***
// Constants for the reset and stop-recovery controller.
// Assumes a 100 MHz clock and a Wishbone slave with 32-bit data.
`ifndef RSC_REGS_VH
`define RSC_REGS_VH
// Register byte offsets (word aligned)
`define RSC_CAUSE_OFS 12'hff0
`define RSC_DBGCTL_OFS 12'hff4
`define RSC_CFG_OFS 12'hff8
`define RSC_STATE_OFS 12'hffc
// Cause status bit positions
`define RSC_CAUSE_POR 7
`define RSC_CAUSE_STOP 6
`define RSC_CAUSE_WDT 5
`define RSC_CAUSE_EXT 4
// Config register bits and reset value
`define RSC_CFG_WDTRST 0
`define RSC_CFG_XTAL 1
`define RSC_CFG_PINRST 2
`define RSC_CFG_RESET 8'h05
// Hold counts in oscillator cycles
`define RSC_HOLD_SHORT 16'h0042
`define RSC_HOLD_LONG 16'h1388
`define RSC_PIN_MIN 3'h4
// Reset vector address
`define RSC_VEC_HI 16'h0002
`define RSC_VEC_LO 16'h0003
`endif

// *** rtl/rsc_reset_ctrl.v ***
// Reset and stop-mode recovery controller with Wishbone registers.
// Assumes clk is the internal precision oscillator and all source strobes are on clk except the pin.
//
// Added by the designer: the Wishbone interface to the registers.
`include "rsc_regs.vh"
module rsc_reset_ctrl (
    // Clock, reset, enable
    input wire clk,
    input wire reset,
    input wire clkEn,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [11:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Reset sources
    input wire porDetect,
    input wire brownoutDetect,
    input wire watchdogTimeout,
    input wire stopMode,
    input wire gpioRecoveryEvent,
    // Shared reset pin, open drain
    input wire resetPinIn_n,
    output reg resetPinOut,
    output reg resetPinOe,
    // Results
    output reg cpuReset,
    output reg periphReset,
    output reg ctrlRegLoad,
    output reg stopCtrlLoad,
    output reg gpioInputMode,
    output reg oscSelectInternal,
    output reg [15:0] resetVectorAddrHi,
    output reg [15:0] resetVectorAddrLo
);
    localparam [3:0] ST_RUN = 4'h1;
    localparam [3:0] ST_SUPPLY = 4'h2;
    localparam [3:0] ST_HOLD = 4'h4;
    localparam [3:0] ST_PINWAIT = 4'h8;

    reg pinSync1_r, pinSync2_r;
    reg [2:0] pinCnt_r;
    reg pinReq_r;
    reg [3:0] state_r;
    reg [15:0] holdCnt_r;
    reg stopRec_r;
    reg [7:0] cause_r;
    reg [7:0] cfg_r;
    reg dbgRst_r;
    wire pinLow = ~pinSync2_r;
    wire wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wbWr = wbReq & wb_we_i & wb_sel_i[0];
    // A debugger write that lands in the same cycle as the clear must win
    wire dbgSet = wbWr && wb_adr_i == `RSC_DBGCTL_OFS && wb_dat_i[0];
    wire [15:0] holdTarget = cfg_r[`RSC_CFG_XTAL] ? `RSC_HOLD_LONG : `RSC_HOLD_SHORT;
    wire supplyBad = porDetect | brownoutDetect;
    wire wdtRst = watchdogTimeout & cfg_r[`RSC_CFG_WDTRST] & ~stopMode;
    wire sysReq = wdtRst | (pinReq_r & cfg_r[`RSC_CFG_PINRST]) | dbgRst_r;
    wire stopReq = stopMode & (watchdogTimeout | gpioRecoveryEvent);

    ////////////////////////////////////////////////////////////////
    // Pin synchroniser and pulse-width filter
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            pinSync1_r <= 1'b1;
            pinSync2_r <= 1'b1;
            pinCnt_r <= 3'h0;
            pinReq_r <= 1'b0;
        end else if (clkEn) begin
            pinSync1_r <= resetPinIn_n;
            pinSync2_r <= pinSync1_r;
            if (!pinLow) begin
                pinCnt_r <= 3'h0;
                pinReq_r <= 1'b0;
            end else if (pinCnt_r != `RSC_PIN_MIN - 3'h1) begin
                pinCnt_r <= pinCnt_r + 3'h1;
            end else begin
                pinReq_r <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Sequencer
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r <= ST_SUPPLY;
            holdCnt_r <= 16'h0000;
            stopRec_r <= 1'b0;
            cause_r <= 8'h80;
            cfg_r <= `RSC_CFG_RESET;
            dbgRst_r <= 1'b0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else if (clkEn) begin
            wb_ack_o <= wbReq;
            if (wbReq) begin
                if (wb_adr_i == `RSC_CAUSE_OFS) begin
                    wb_dat_o <= {24'h0, cause_r};
                end else if (wb_adr_i == `RSC_DBGCTL_OFS) begin
                    wb_dat_o <= {31'h0, dbgRst_r};
                end else if (wb_adr_i == `RSC_CFG_OFS) begin
                    wb_dat_o <= {24'h0, cfg_r};
                end else if (wb_adr_i == `RSC_STATE_OFS) begin
                    wb_dat_o <= {28'h0, state_r};
                end else begin
                    wb_dat_o <= 32'h0;
                end
            end
            if (wbWr && wb_adr_i == `RSC_CFG_OFS) begin
                cfg_r <= {5'h0, wb_dat_i[2:0]};
            end
            if (dbgSet) begin
                dbgRst_r <= 1'b1;
            end
            if (supplyBad) begin
                state_r <= ST_SUPPLY;
                holdCnt_r <= 16'h0000;
                stopRec_r <= 1'b0;
                cause_r <= 8'h80;
            end else begin
                case (state_r)
                    ST_SUPPLY: begin
                        state_r <= ST_HOLD;
                        holdCnt_r <= 16'h0000;
                        cfg_r <= `RSC_CFG_RESET;
                    end
                    ST_RUN: begin
                        holdCnt_r <= 16'h0000;
                        if (sysReq) begin
                            state_r <= ST_HOLD;
                            stopRec_r <= 1'b0;
                            cfg_r <= `RSC_CFG_RESET;
                            cause_r <= 8'h00;
                            cause_r[`RSC_CAUSE_WDT] <= wdtRst;
                            cause_r[`RSC_CAUSE_EXT] <= pinReq_r & cfg_r[`RSC_CFG_PINRST];
                            cause_r[`RSC_CAUSE_POR] <= dbgRst_r;
                        end else if (stopReq) begin
                            state_r <= ST_HOLD;
                            stopRec_r <= 1'b1;
                            cause_r <= 8'h00;
                            cause_r[`RSC_CAUSE_STOP] <= 1'b1;
                            cause_r[`RSC_CAUSE_WDT] <= watchdogTimeout;
                        end
                    end
                    ST_HOLD: begin
                        if (!dbgSet) begin
                            dbgRst_r <= 1'b0;
                        end
                        if (holdCnt_r + 16'h0001 >= holdTarget) begin
                            // Our own pull-down hides the outside level, so always
                            // release the pin and look at it once it has settled
                            state_r <= ST_PINWAIT;
                        end else begin
                            holdCnt_r <= holdCnt_r + 16'h0001;
                        end
                    end
                    ST_PINWAIT: begin
                        if (!pinLow) begin
                            state_r <= ST_RUN;
                        end
                    end
                    default: begin
                        state_r <= ST_SUPPLY;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Registered outputs
    // The pin is pulled low only while counting; in the pin wait it is
    // released so that the synchroniser sees the outside level again.
    wire inReset = (state_r != ST_RUN);
    wire sysReset = inReset & ~stopRec_r;
    wire countPhase = (state_r == ST_SUPPLY) | (state_r == ST_HOLD);
    reg cpuReset_nxt;
    reg periphReset_nxt;
    reg ctrlRegLoad_nxt;
    reg stopCtrlLoad_nxt;
    reg gpioInputMode_nxt;
    reg oscSelectInternal_nxt;
    reg resetPinOe_nxt;
    always @* begin
        cpuReset_nxt = inReset;
        periphReset_nxt = sysReset;
        ctrlRegLoad_nxt = sysReset;
        stopCtrlLoad_nxt = inReset;
        gpioInputMode_nxt = sysReset;
        oscSelectInternal_nxt = inReset;
        resetPinOe_nxt = sysReset & countPhase;
    end
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            cpuReset <= 1'b1;
            periphReset <= 1'b1;
            ctrlRegLoad <= 1'b1;
            stopCtrlLoad <= 1'b1;
            gpioInputMode <= 1'b1;
            oscSelectInternal <= 1'b1;
            resetPinOut <= 1'b0;
            resetPinOe <= 1'b1;
            resetVectorAddrHi <= `RSC_VEC_HI;
            resetVectorAddrLo <= `RSC_VEC_LO;
        end else if (clkEn) begin
            // Oscillators live outside this block and are never gated here
            cpuReset <= cpuReset_nxt;
            periphReset <= periphReset_nxt;
            ctrlRegLoad <= ctrlRegLoad_nxt;
            stopCtrlLoad <= stopCtrlLoad_nxt;
            gpioInputMode <= gpioInputMode_nxt;
            oscSelectInternal <= oscSelectInternal_nxt;
            resetPinOut <= 1'b0;
            resetPinOe <= resetPinOe_nxt;
            resetVectorAddrHi <= `RSC_VEC_HI;
            resetVectorAddrLo <= `RSC_VEC_LO;
        end
    end
endmodule // rsc_reset_ctrl

// *** tb/rsc_pin_model.sv ***
// Shared reset pin: pull-up, outside driver and the block's open drain.
// Assumes the block pulls low only while resetPinOe is high.
module rsc_pin_model (
    input logic extLow,
    input logic resetPinOe,
    input logic resetPinOut,
    output logic resetPinIn_n
);
    timeunit 1ns;
    timeprecision 1ns;
    // Pull-up wins when nobody drives, so a released pin never holds a stale low
    assign resetPinIn_n = !(extLow || (resetPinOe && !resetPinOut));
endmodule // rsc_pin_model

// *** tb/rsc_reset_ctrl_sva.sv ***
// Port assertions for the reset controller.
// Assumes one clock and clkEn held high by the bench.
module rsc_reset_ctrl_sva (
    input logic clk, reset, clkEn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
    input logic [11:0] wb_adr_i,
    input logic [3:0] wb_sel_i,
    input logic [31:0] wb_dat_i,
    input logic porDetect, brownoutDetect, stopMode, gpioRecoveryEvent, resetPinOut, resetPinOe,
    input logic cpuReset, periphReset, ctrlRegLoad, stopCtrlLoad, gpioInputMode, oscSelectInternal,
    input logic [15:0] resetVectorAddrHi, resetVectorAddrLo
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic [15:0] holdCnt;
    always @(posedge clk or posedge reset) begin
        if (reset)
            holdCnt <= 16'h0;
        else
            holdCnt <= cpuReset ? holdCnt + 16'h1 : 16'h0;
    end
    sequence s_dbgWr;
        wb_ack_o && wb_we_i && wb_adr_i == 12'hff4 && wb_sel_i[0] && wb_dat_i[0];
    endsequence
    sequence s_sysHold;
        cpuReset && periphReset && ctrlRegLoad;
    endsequence
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && clkEn |=> wb_ack_o)
        else $error("ack late");
    a_dbg_starts_reset: assert property (s_dbgWr |-> ##[1:3] s_sysHold) else $error("no debug reset");
    a_supply_resets: assert property (porDetect || brownoutDetect |-> ##[1:2] s_sysHold)
        else $error("no supply reset");
    a_stop_recovery: assert property (stopMode && gpioRecoveryEvent && !cpuReset
        |-> ##[1:3] (cpuReset && stopCtrlLoad && !ctrlRegLoad)) else $error("bad recovery");
    a_sys_outputs: assert property (ctrlRegLoad |-> gpioInputMode && oscSelectInternal)
        else $error("reset outputs wrong");
    a_pin_in_reset: assert property (resetPinOe |-> ctrlRegLoad && cpuReset)
        else $error("pin driven outside reset");
    a_pin_open_drain: assert property (resetPinOe |-> !resetPinOut) else $error("pin driven high");
    a_hold_min: assert property ($fell(cpuReset) |-> holdCnt >= 16'h0042) else $error("hold short");
    a_vector_fixed: assert property (resetVectorAddrHi == 16'h0002 && resetVectorAddrLo == 16'h0003)
        else $error("vector address wrong");
endmodule // rsc_reset_ctrl_sva
bind rsc_reset_ctrl rsc_reset_ctrl_sva chk (.*);

// *** tb/test_rsc_reset_ctrl.sv ***
// Bench for the reset controller: Wishbone tasks and reset scenarios.
// Assumes the pin model resolves the shared reset pin.
module test_rsc_reset_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, reset = 1'b1, clkEn = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
    logic [11:0] wb_adr_i = 12'h0;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    logic porDetect = 1'b1, brownoutDetect = 1'b0, watchdogTimeout = 1'b0, stopMode = 1'b0;
    logic gpioRecoveryEvent = 1'b0, extLow = 1'b0, resetPinIn_n, resetPinOut, resetPinOe, cpuReset;
    logic periphReset, ctrlRegLoad, stopCtrlLoad, gpioInputMode, oscSelectInternal;
    logic [15:0] resetVectorAddrHi, resetVectorAddrLo;
    int fail_count = 0, total_checks = 0, n;
    rsc_reset_ctrl dut (.*);
    rsc_pin_model pin (.*);
    initial forever #5 clk = ~clk;
    ////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic bad(input string m);
        fail_count++;
        $display("[FAIL] %0t %s", $time, m);
    endtask
    task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
            bad($sformatf("got %h exp %h", got, exp));
    endtask
    task automatic chkCnt(input int got, input int lo, input int hi);
        total_checks++;
        if (got < lo || got > hi)
            bad($sformatf("count %0d", got));
    endtask
    // Bounded wait for cpuReset to reach lvl; n returns the cycles taken
    task automatic waitRst(input logic lvl, input int lim);
        n = 0;
        while (cpuReset !== lvl && n < lim) begin
            @(posedge clk);
            n++;
        end
        if (n >= lim) begin
            bad("wait timed out");
            stop_test();
        end
    endtask
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        if (k >= 20) begin
            bad("no ack");
            stop_test();
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        repeat (20) @(posedge clk);
        porDetect <= 1'b0;
        waitRst(1'b0, 200);
        chkCnt(n, 66, 76);
        xfer(1'b0, 12'hff0, 32'h0);
        chkVal(q & 32'hf0, 32'h80);
        xfer(1'b0, 12'hff8, 32'h0);
        chkVal(q, 32'h5);
        xfer(1'b0, 12'h100, 32'h0);
        chkVal(q, 32'h0);
        xfer(1'b1, 12'hff4, 32'h1);
        waitRst(1'b1, 5);
        waitRst(1'b0, 100);
        chkCnt(n, 66, 76);
        xfer(1'b0, 12'hff4, 32'h0);
        chkVal(q, 32'h0);
        watchdogTimeout <= 1'b1;
        @(posedge clk);
        watchdogTimeout <= 1'b0;
        waitRst(1'b1, 5);
        waitRst(1'b0, 100);
        xfer(1'b0, 12'hff0, 32'h0);
        chkVal(q & 32'hf0, 32'h20);
        xfer(1'b1, 12'hff8, 32'h4);
        watchdogTimeout <= 1'b1;
        @(posedge clk);
        watchdogTimeout <= 1'b0;
        repeat (10) @(posedge clk);
        chkVal({31'h0, cpuReset}, 32'h0);
        // A three-cycle low must not reach the reset logic
        extLow <= 1'b1;
        repeat (3) @(posedge clk);
        extLow <= 1'b0;
        repeat (10) @(posedge clk);
        chkVal({31'h0, cpuReset}, 32'h0);
        // A four-cycle low must reset while the pin reset enable bit is set
        extLow <= 1'b1;
        repeat (4) @(posedge clk);
        extLow <= 1'b0;
        waitRst(1'b1, 10);
        waitRst(1'b0, 100);
        xfer(1'b0, 12'hff0, 32'h0);
        chkVal(q & 32'hf0, 32'h10);
        extLow <= 1'b1;
        repeat (200) @(posedge clk);
        chkVal({31'h0, cpuReset}, 32'h1);
        extLow <= 1'b0;
        waitRst(1'b0, 10);
        xfer(1'b0, 12'hff0, 32'h0);
        chkVal(q & 32'hf0, 32'h10);
        xfer(1'b0, 12'hff8, 32'h0);
        chkVal(q, 32'h5);
        brownoutDetect <= 1'b1;
        waitRst(1'b1, 5);
        @(posedge clk);
        chkVal({28'h0, resetPinOe, gpioInputMode, oscSelectInternal, periphReset}, 32'hf);
        brownoutDetect <= 1'b0;
        waitRst(1'b0, 100);
        xfer(1'b1, 12'hff8, 32'h7);
        stopMode <= 1'b1;
        gpioRecoveryEvent <= 1'b1;
        @(posedge clk);
        gpioRecoveryEvent <= 1'b0;
        waitRst(1'b1, 5);
        chkVal({31'h0, ctrlRegLoad}, 32'h0);
        waitRst(1'b0, 6000);
        chkCnt(n, 4990, 5010);
        stopMode <= 1'b0;
        xfer(1'b0, 12'hff8, 32'h0);
        chkVal(q, 32'h7);
        xfer(1'b0, 12'hff0, 32'h0);
        chkVal(q & 32'hf0, 32'h40);
        stop_test();
    end
endmodule // test_rsc_reset_ctrl
